// *** verilog/prot_pkg.sv ***
// Shared constants and register map of the output protection supervisor.
package prot_pkg;
   // Bus and data widths.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int MEAS_W = 16;
   localparam int TIME_W = 16;
   localparam int CNT_W  = 18;

   // Check indices: five user checks plus sense reversal, then over-temperature.
   localparam int CHK_OV    = 0;
   localparam int CHK_OC    = 1;
   localparam int CHK_OP    = 2;
   localparam int CHK_UC    = 3;
   localparam int CHK_UV    = 4;
   localparam int CHK_SENSE = 5;
   localparam int CHK_OTP   = 6;
   localparam int N_LIM     = 5;
   localparam int N_QUAL    = 6;
   localparam int N_TRIP    = 7;

   // Register byte addresses.
   localparam logic [ADDR_W-1:0] CTRL_ADDR   = 8'h00;
   localparam logic [ADDR_W-1:0] OUTPUT_ADDR = 8'h04;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h08;
   localparam logic [ADDR_W-1:0] CLEAR_ADDR  = 8'h0C;
   localparam logic [ADDR_W-1:0] LIMIT_BASE  = 8'h10;
   localparam logic [ADDR_W-1:0] DELAY_BASE  = 8'h24;
   localparam logic [ADDR_W-1:0] UCWARM_ADDR = 8'h38;
   localparam logic [ADDR_W-1:0] UVWARM_ADDR = 8'h3C;
   localparam logic [ADDR_W-1:0] SENSE_ADDR  = 8'h40;
   localparam logic [ADDR_W-1:0] TEMP_ADDR   = 8'h44;

   // Control and status register fields.
   localparam int CTRL_SENSE_EN  = 5;
   localparam int CTRL_SENSE_SW  = 6;
   localparam int CTRL_BEEP_EN   = 7;
   localparam int CTRL_W         = 8;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 8'hA0;
   localparam int STATUS_OUT_BIT = 8;

   // Bus responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Timing: 1 ms timer tick derived from the 50 ns clock.
   localparam int CLK_PERIOD_NS = 50;
   localparam int TICK_NS       = 1000000;
   localparam int SENSE_QUAL_MS = 500;
   localparam int BEEP_MS       = 200;
   localparam logic [TIME_W-1:0] SENSE_QUAL_TICKS = TIME_W'(SENSE_QUAL_MS * 1000000 / TICK_NS);
   localparam logic [TIME_W-1:0] BEEP_TICKS       = TIME_W'(BEEP_MS * 1000000 / TICK_NS);

   // Fixed over-temperature threshold in whole degrees Celsius.
   localparam logic signed [MEAS_W-1:0] OTP_LIMIT_C = 16'sh005A;

   // Bus transaction phase of the write channel.
   typedef enum logic [2:0] {
      WR_IDLE = 3'b001,
      WR_COLLECT = 3'b010,
      WR_RESP = 3'b100
   } wr_state_t;
endpackage : prot_pkg

// *** verilog/fault_qualifier.sv ***
// Persistence timer that qualifies one fault condition over warm-up plus delay.
`timescale 1ns/100ps
module fault_qualifier
   import prot_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              tick,
   input  wire logic              arm,
   input  wire logic              cond,
   input  wire logic [TIME_W-1:0] warm,
   input  wire logic [TIME_W-1:0] delay,
   output logic                   qualified
);
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] total;

   assign total = CNT_W'(warm) + CNT_W'(delay);

   // Counts ticks of an unbroken fault; any gap restarts from zero.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !arm || !cond)
      begin
         count_r <= '0;
      end
      else if (tick && count_r <= total)
      begin
         count_r <= count_r + CNT_W'(1);
      end
   end

   // The limit must be exceeded for longer than the window, hence strictly greater.
   assign qualified = arm && cond && (count_r > total);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_restart;
      !cond |=> count_r == '0;
   endproperty
   a_restart: assert property (p_restart) else $error("timer not restarted");
endmodule : fault_qualifier

// *** verilog/prot_supervisor.sv ***
// Output protection supervisor with limit checks, trips and an AXI4-Lite register file.
//
// Functional notes
// - Over-voltage beyond delay latches voltage trip.
// - Over-current beyond delay latches current trip.
// - Over-power beyond delay latches power trip.
// - Under-current after warm-up plus delay trips.
// - Under-voltage after warm-up plus delay trips.
// - Current limits compare magnitudes, both directions.
// - Power limit compares magnitude, both directions.
// - Temperature above fixed threshold trips.
// - Temperature threshold fixed, decided internally.
// - Sense check default on, needs sense switch.
// - Sense difference while on trips after 500ms.
// - Sense trip switches output off at once.
// - Qualified persistent fault disables the output.
// - Protection entry: buzzer, indicators, output off.
`timescale 1ns/100ps
module prot_supervisor
   import prot_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS
)
(
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [DATA_W-1:0]        s_axi_wdata,
   input  wire logic [DATA_W/8-1:0]      s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [ADDR_W-1:0]        s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [DATA_W-1:0]             s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   input  wire logic signed [MEAS_W-1:0] meas_voltage,
   input  wire logic signed [MEAS_W-1:0] meas_current,
   input  wire logic signed [MEAS_W-1:0] meas_power,
   input  wire logic signed [MEAS_W-1:0] terminal_voltage,
   input  wire logic signed [MEAS_W-1:0] sense_voltage,
   input  wire logic signed [MEAS_W-1:0] temperature_c,
   output logic                          output_enable,
   output logic                          prot_indicator,
   output logic                          off_indicator,
   output logic                          buzzer,
   output logic [N_TRIP-1:0]             fault_message
);
   logic [CTRL_W-1:0]             ctrl_r;
   logic signed [MEAS_W-1:0]      limit_r [N_LIM];
   logic [TIME_W-1:0]             delay_r [N_LIM];
   logic [TIME_W-1:0]             uc_warm_r;
   logic [TIME_W-1:0]             uv_warm_r;
   logic [MEAS_W-1:0]             sense_thr_r;
   logic [N_TRIP-1:0]             trip_r;
   logic [N_TRIP-1:0]             trip_set;
   logic [N_TRIP-1:0]             trip_clr;
   logic                          out_on_r;
   logic                          out_wr;
   logic [TIME_W-1:0]             beep_cnt_r;
   logic [$clog2(TICK_CYCLES)-1:0] div_r;
   logic                          tick;
   logic [N_QUAL-1:0]             cond;
   logic [N_QUAL-1:0]             arm;
   logic [N_QUAL-1:0]             qualified;
   logic [TIME_W-1:0]             q_warm  [N_QUAL];
   logic [TIME_W-1:0]             q_delay [N_QUAL];
   logic [MEAS_W:0]               sense_diff;
   logic                          new_entry;
   wr_state_t                     wr_state_r;
   logic                          aw_hold_r;
   logic                          w_hold_r;
   logic [ADDR_W-1:0]             awaddr_r;
   logic [DATA_W-1:0]             wdata_r;
   logic [DATA_W/8-1:0]           wstrb_r;
   logic                          do_wr;
   logic [DATA_W-1:0]             wmask;
   logic [DATA_W-1:0]             rd_data;
   logic [1:0]                    rd_resp;
   logic [2:0]                    widx;
   logic [2:0]                    ridx;

   // Magnitude of a sign-extended value, so one limit covers both directions.
   function automatic logic [MEAS_W:0] mag(input logic signed [MEAS_W:0] v);
      mag = v[MEAS_W] ? MEAS_W'(1'b0) + (MEAS_W+1)'(-v) : (MEAS_W+1)'(v);
   endfunction : mag

   // Millisecond tick; every protection time is counted in these ticks.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || tick)
      begin
         div_r <= '0;
      end
      else
      begin
         div_r <= div_r + 1'b1;
      end
   end
   assign tick = (div_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));

   // Raw limit comparisons.
   assign sense_diff = {terminal_voltage[MEAS_W-1], terminal_voltage}
                     - {sense_voltage[MEAS_W-1], sense_voltage};
   always_comb
   begin
      cond[CHK_OV]    = meas_voltage > limit_r[CHK_OV];
      cond[CHK_OC]    = mag({meas_current[MEAS_W-1], meas_current})
                      > mag({limit_r[CHK_OC][MEAS_W-1], limit_r[CHK_OC]});
      cond[CHK_OP]    = mag({meas_power[MEAS_W-1], meas_power})
                      > mag({limit_r[CHK_OP][MEAS_W-1], limit_r[CHK_OP]});
      cond[CHK_UC]    = mag({meas_current[MEAS_W-1], meas_current})
                      < mag({limit_r[CHK_UC][MEAS_W-1], limit_r[CHK_UC]});
      cond[CHK_UV]    = meas_voltage < limit_r[CHK_UV];
      cond[CHK_SENSE] = mag(sense_diff) > {1'b0, sense_thr_r};
   end

   // Arming: under-limit and sense checks only make sense while the output runs.
   always_comb
   begin
      arm = ctrl_r[N_QUAL-1:0];
      arm[CHK_UC] = ctrl_r[CHK_UC] && out_on_r;
      arm[CHK_UV] = ctrl_r[CHK_UV] && out_on_r;
      arm[CHK_SENSE] = ctrl_r[CTRL_SENSE_EN] && ctrl_r[CTRL_SENSE_SW] && out_on_r;
      q_warm = '{default: '0};
      q_delay[CHK_SENSE] = SENSE_QUAL_TICKS;
      for (int k = 0; k < N_LIM; k++)
      begin
         q_delay[k] = delay_r[k];
      end
      q_warm[CHK_UC] = uc_warm_r;
      q_warm[CHK_UV] = uv_warm_r;
   end

   // One persistence timer per qualified check.
   for (genvar g = 0; g < N_QUAL; g++)
   begin : g_qual
      fault_qualifier u_qual (
         .aclk      (aclk),
         .aresetn   (aresetn),
         .tick      (tick),
         .arm       (arm[g]),
         .cond      (cond[g]),
         .warm      (q_warm[g]),
         .delay     (q_delay[g]),
         .qualified (qualified[g])
      );
   end

   // Over-temperature needs no timer or limit register.
   assign trip_set = {temperature_c > OTP_LIMIT_C, qualified};
   assign new_entry = |(trip_set & ~trip_r);

   // Latched trips; a new fault wins over a clear in the same cycle.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         trip_r <= '0;
      end
      else
      begin
         trip_r <= (trip_r & ~trip_clr) | trip_set;
      end
   end

   // Output switch: any trip forces it off, only an explicit write turns it on.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         out_on_r <= 1'b0;
      end
      else if (|trip_set)
      begin
         out_on_r <= 1'b0;
      end
      else if (out_wr)
      begin
         out_on_r <= wdata_r[0] && (trip_r & ~trip_clr) == '0;
      end
   end

   // Buzzer runs for a fixed beep length on each new protection entry.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         beep_cnt_r <= '0;
      end
      else if (new_entry && ctrl_r[CTRL_BEEP_EN])
      begin
         beep_cnt_r <= BEEP_TICKS;
      end
      else if (tick && beep_cnt_r != '0)
      begin
         beep_cnt_r <= beep_cnt_r - 1'b1;
      end
   end

   assign output_enable  = out_on_r;
   assign prot_indicator = |trip_r;
   assign off_indicator  = !out_on_r;
   assign buzzer         = beep_cnt_r != '0;
   assign fault_message  = trip_r;

   // Write channel: address and data are caught in either order, then answered.
   assign s_axi_awready = !aw_hold_r && wr_state_r != WR_RESP;
   assign s_axi_wready  = !w_hold_r && wr_state_r != WR_RESP;
   assign do_wr = aw_hold_r && w_hold_r && wr_state_r != WR_RESP;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_state_r <= WR_IDLE;
         aw_hold_r  <= 1'b0;
         w_hold_r   <= 1'b0;
         awaddr_r   <= '0;
         wdata_r    <= '0;
         wstrb_r    <= '0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         case (wr_state_r)
            WR_IDLE, WR_COLLECT:
            begin
               if (do_wr)
               begin
                  wr_state_r <= WR_RESP;
                  aw_hold_r  <= 1'b0;
                  w_hold_r   <= 1'b0;
               end
               else if (aw_hold_r || w_hold_r)
               begin
                  wr_state_r <= WR_COLLECT;
               end
            end
            WR_RESP:
            begin
               if (s_axi_bready)
               begin
                  wr_state_r <= WR_IDLE;
               end
            end
            default:
            begin
               wr_state_r <= WR_IDLE;
            end
         endcase
      end
   end
   assign s_axi_bvalid = wr_state_r == WR_RESP;

   // Byte lanes expanded to a bit mask.
   for (genvar b = 0; b < DATA_W/8; b++)
   begin : g_mask
      assign wmask[b*8 +: 8] = {8{wstrb_r[b]}};
   end
   assign widx = 3'((awaddr_r - LIMIT_BASE) >> 2);
   assign out_wr = do_wr && awaddr_r == OUTPUT_ADDR;
   assign trip_clr = (do_wr && awaddr_r == CLEAR_ADDR) ? N_TRIP'(wdata_r & wmask) : '0;

   // Register writes and the write response code.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_r      <= CTRL_RESET;
         limit_r     <= '{default: '0};
         delay_r     <= '{default: '0};
         uc_warm_r   <= '0;
         uv_warm_r   <= '0;
         sense_thr_r <= '0;
         s_axi_bresp <= RESP_OKAY;
      end
      else if (do_wr)
      begin
         s_axi_bresp <= RESP_OKAY;
         if (awaddr_r == CTRL_ADDR)
         begin
            ctrl_r <= (ctrl_r & ~wmask[CTRL_W-1:0]) | (wdata_r[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
         end
         else if (awaddr_r == OUTPUT_ADDR || awaddr_r == CLEAR_ADDR
                  || awaddr_r == STATUS_ADDR || awaddr_r == TEMP_ADDR)
         begin
            s_axi_bresp <= RESP_OKAY;
         end
         else if (awaddr_r >= LIMIT_BASE && awaddr_r < DELAY_BASE)
         begin
            limit_r[widx] <= (limit_r[widx] & ~wmask[MEAS_W-1:0])
                           | (wdata_r[MEAS_W-1:0] & wmask[MEAS_W-1:0]);
         end
         else if (awaddr_r >= DELAY_BASE && awaddr_r < UCWARM_ADDR)
         begin
            delay_r[3'(widx - 3'(N_LIM))] <= wdata_r[TIME_W-1:0];
         end
         else if (awaddr_r == UCWARM_ADDR)
         begin
            uc_warm_r <= wdata_r[TIME_W-1:0];
         end
         else if (awaddr_r == UVWARM_ADDR)
         begin
            uv_warm_r <= wdata_r[TIME_W-1:0];
         end
         else if (awaddr_r == SENSE_ADDR)
         begin
            sense_thr_r <= wdata_r[MEAS_W-1:0];
         end
         else
         begin
            s_axi_bresp <= RESP_SLVERR;
         end
      end
   end

   // Read decode; unmapped addresses read zero with an error response.
   assign ridx = 3'((s_axi_araddr - LIMIT_BASE) >> 2);
   always_comb
   begin
      rd_data = '0;
      rd_resp = RESP_OKAY;
      if (s_axi_araddr == CTRL_ADDR)
      begin
         rd_data = DATA_W'(ctrl_r);
      end
      else if (s_axi_araddr == OUTPUT_ADDR)
      begin
         rd_data = DATA_W'(out_on_r);
      end
      else if (s_axi_araddr == STATUS_ADDR)
      begin
         rd_data = DATA_W'(trip_r);
         rd_data[STATUS_OUT_BIT] = out_on_r;
      end
      else if (s_axi_araddr == CLEAR_ADDR)
      begin
         rd_data = '0;
      end
      else if (s_axi_araddr >= LIMIT_BASE && s_axi_araddr < DELAY_BASE)
      begin
         rd_data = DATA_W'($unsigned(limit_r[ridx]));
      end
      else if (s_axi_araddr >= DELAY_BASE && s_axi_araddr < UCWARM_ADDR)
      begin
         rd_data = DATA_W'(delay_r[3'(ridx - 3'(N_LIM))]);
      end
      else if (s_axi_araddr == UCWARM_ADDR)
      begin
         rd_data = DATA_W'(uc_warm_r);
      end
      else if (s_axi_araddr == UVWARM_ADDR)
      begin
         rd_data = DATA_W'(uv_warm_r);
      end
      else if (s_axi_araddr == SENSE_ADDR)
      begin
         rd_data = DATA_W'(sense_thr_r);
      end
      else if (s_axi_araddr == TEMP_ADDR)
      begin
         rd_data = DATA_W'($unsigned(temperature_c));
      end
      else
      begin
         rd_resp = RESP_SLVERR;
      end
   end

   // Read channel: one read at a time, data held until taken.
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_data;
         s_axi_rresp  <= rd_resp;
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_enter;
      new_entry;
   endsequence
   property p_entry_off;
      s_enter |=> !output_enable && prot_indicator && off_indicator;
   endproperty
   a_entry_off: assert property (p_entry_off) else $error("output left on at trip");
   property p_beep;
      s_enter ##0 ctrl_r[CTRL_BEEP_EN] |=> buzzer [*2];
   endproperty
   a_beep: assert property (p_beep) else $error("no buzzer on protection");
   property p_latch;
      trip_r[CHK_OV] && !trip_clr[CHK_OV] |=> trip_r[CHK_OV];
   endproperty
   a_latch: assert property (p_latch) else $error("trip dropped without clear");
   property p_otp;
      temperature_c > OTP_LIMIT_C |=> trip_r[CHK_OTP] && !output_enable;
   endproperty
   a_otp: assert property (p_otp) else $error("temperature trip missed");
   property p_ov;
      $rose(trip_r[CHK_OV]) |-> $past(ctrl_r[CHK_OV] && meas_voltage > limit_r[CHK_OV]);
   endproperty
   a_ov: assert property (p_ov) else $error("voltage trip without cause");
   property p_uc;
      $rose(trip_r[CHK_UC]) |-> $past(out_on_r && cond[CHK_UC]);
   endproperty
   a_uc: assert property (p_uc) else $error("under-current trip without cause");
   property p_sense;
      $rose(trip_r[CHK_SENSE]) |-> $past(ctrl_r[CTRL_SENSE_SW]) && !output_enable;
   endproperty
   a_sense: assert property (p_sense) else $error("sense trip while switch off");
   property p_no_reopen;
      !out_on_r && !out_wr |=> !output_enable;
   endproperty
   a_no_reopen: assert property (p_no_reopen) else $error("output reopened by itself");
endmodule : prot_supervisor

// *** bench/supply_model.sv ***
// Behavioural model of the measurement path, power stage and sense leads.
`timescale 1ns/100ps
module supply_model
   import prot_pkg::*;
(
   input  wire logic                     output_enable,
   input  wire logic signed [MEAS_W-1:0] v_set,
   input  wire logic signed [MEAS_W-1:0] i_set,
   input  wire logic signed [MEAS_W-1:0] p_set,
   input  wire logic signed [MEAS_W-1:0] t_set,
   input  wire logic                     sense_rev,
   output logic signed [MEAS_W-1:0]      meas_voltage,
   output logic signed [MEAS_W-1:0]      meas_current,
   output logic signed [MEAS_W-1:0]      meas_power,
   output logic signed [MEAS_W-1:0]      terminal_voltage,
   output logic signed [MEAS_W-1:0]      sense_voltage,
   output logic signed [MEAS_W-1:0]      temperature_c
);
   // An idle stage delivers nothing, so every reading but temperature drops to zero while off.
   assign meas_voltage = output_enable ? v_set : '0;
   assign meas_current = output_enable ? i_set : '0;
   assign meas_power = output_enable ? p_set : '0;
   assign terminal_voltage = meas_voltage;
   // Swapped leads show the terminal voltage with its sign turned round.
   assign sense_voltage = sense_rev ? -meas_voltage : meas_voltage;
   assign temperature_c = t_set;
endmodule : supply_model

// *** bench/prot_supervisor_test.sv ***
// Self-checking bench of the output protection supervisor.
`timescale 1ns/100ps
module prot_supervisor_test;
   import prot_pkg::*;
   localparam int TK = 20;
   typedef struct {int idx; logic [15:0] lim, v, i, p; int w;} row_t;
   // One row per user check: limit and faulting readings; w is the warm-up.
   row_t rows [5] = '{'{0, 16'h05DC, 16'h07D0, 16'h0064, 16'h0064, 0},
                      '{1, 16'hFED4, 16'h03E8, 16'hFE70, 16'h0064, 0},
                      '{2, 16'h01F4, 16'h03E8, 16'h0064, 16'hFDA8, 0},
                      '{3, 16'hFED4, 16'h03E8, 16'h0032, 16'h0064, 2},
                      '{4, 16'h01F4, 16'h00C8, 16'h0064, 16'h0064, 2}};
   logic               aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic               arvalid, arready, rvalid, rready, oe, prot, offi, buzz, rev;
   logic [7:0]         awaddr, araddr;
   logic [31:0]        wdata, rdata, rd;
   logic [1:0]         bresp, rresp, resp;
   logic [6:0]         fmsg;
   logic signed [15:0] v_set, i_set, p_set, t_set, mv, mi, mp, tv, sv, tc;
   int                 fail_count, compares, cyc;
   row_t               r;

   prot_supervisor #(.TICK_CYCLES(TK)) dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .meas_voltage(mv), .meas_current(mi), .meas_power(mp), .terminal_voltage(tv),
      .sense_voltage(sv), .temperature_c(tc), .output_enable(oe), .prot_indicator(prot),
      .off_indicator(offi), .buzzer(buzz), .fault_message(fmsg));

   supply_model model (.output_enable(oe), .v_set(v_set), .i_set(i_set), .p_set(p_set),
      .t_set(t_set), .sense_rev(rev), .meas_voltage(mv), .meas_current(mi),
      .meas_power(mp), .terminal_voltage(tv), .sense_voltage(sv), .temperature_c(tc));

   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   // A hung handshake must not stall the run, so cycles are capped.
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         fail_count++;
         test_done();
      end
   end

   task automatic test_done;
      begin
         if (fail_count == 0 && compares > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask : test_done

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      begin
         compares++;
         if (g !== e)
         begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask : chk

   // Handshakes are judged at the falling edge, where every level has settled.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ha, hw, hb;
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         hb = 1'b0;
         while (!hb)
         begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
         end
         bready <= 1'b0;
      end
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      logic ha, hr;
      begin
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         hr = 1'b0;
         while (!hr)
         begin
            @(negedge aclk);
            ha = arvalid && arready;
            hr = rvalid;
            rd = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 1'b0;
         end
         rready <= 1'b0;
      end
   endtask : rdr

   task automatic wt(input int t);
      begin
         repeat (t * TK) @(posedge aclk);
         @(negedge aclk);
      end
   endtask : wt

   task automatic meas(input logic [15:0] v, input logic [15:0] i, input logic [15:0] p);
      begin
         @(posedge aclk);
         v_set <= v;
         i_set <= i;
         p_set <= p;
      end
   endtask : meas

   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready, rev, aresetn} = '0;
      {awaddr, araddr, wdata, fail_count, compares, cyc} = '0;
      {v_set, i_set, p_set, t_set} = {16'h03E8, 16'h0064, 16'h0064, 16'h0019};
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk(32'({oe, offi, prot, buzz, fmsg}), 32'h0000_0200);
      rdr(CTRL_ADDR);
      chk(rd, 32'h0000_00A0);
      rdr(8'h80);
      chk(rd, 32'h0000_0000);
      chk(32'(resp), 32'(RESP_SLVERR));
      wr(8'h80, 32'h0000_0001);
      chk(32'(resp), 32'(RESP_SLVERR));
      wr(STATUS_ADDR, 32'h0000_007F);
      chk(32'(resp), 32'(RESP_OKAY));
      rdr(STATUS_ADDR);
      chk(rd, 32'h0000_0000);
      wr(UCWARM_ADDR, 32'h0000_0002);
      wr(UVWARM_ADDR, 32'h0000_0002);
      // Each check alone: early sample stays clean, late one must have tripped.
      foreach (rows[k])
      begin
         r = rows[k];
         wr(CTRL_ADDR, 32'h0000_00A0 | (32'h1 << r.idx));
         wr(LIMIT_BASE + 8'(4 * r.idx), {16'h0000, r.lim});
         wr(DELAY_BASE + 8'(4 * r.idx), 32'h0000_0003);
         wr(CLEAR_ADDR, 32'h0000_007F);
         wr(OUTPUT_ADDR, 32'h0000_0001);
         meas(r.v, r.i, r.p);
         wt(2 + r.w);
         chk(32'(fmsg), 32'h0000_0000);
         wt(4);
         chk(32'({buzz, prot, offi, oe, fmsg}), {21'h0, 4'hE, 7'(1 << r.idx)});
         meas(16'h03E8, 16'h0064, 16'h0064);
         wr(OUTPUT_ADDR, 32'h0000_0001);
         rdr(STATUS_ADDR);
         chk(rd, 32'h1 << r.idx);
      end
      // Two short bursts with a gap in between must not add up to a trip.
      wr(CTRL_ADDR, 32'h0000_00A1);
      wr(CLEAR_ADDR, 32'h0000_007F);
      wr(OUTPUT_ADDR, 32'h0000_0001);
      repeat (2)
      begin
         meas(16'h07D0, 16'h0064, 16'h0064);
         wt(2);
         meas(16'h03E8, 16'h0064, 16'h0064);
         wt(1);
      end
      chk(32'({oe, fmsg}), 32'h0000_0080);
      @(posedge aclk) t_set <= 16'h005A;
      wt(2);
      chk(32'(fmsg), 32'h0000_0000);
      @(posedge aclk) t_set <= 16'h005B;
      wt(1);
      chk(32'({oe, prot, fmsg}), 32'h0000_00C0);
      @(posedge aclk) t_set <= 16'h0019;
      wr(CLEAR_ADDR, 32'h0000_007F);
      chk(32'({oe, fmsg}), 32'h0000_0000);
      wr(OUTPUT_ADDR, 32'h0000_0001);
      wt(1);
      chk(32'(oe), 32'h0000_0001);
      wr(SENSE_ADDR, 32'h0000_0064);
      wr(CTRL_ADDR, 32'h0000_00A0);
      @(posedge aclk) rev <= 1'b1;
      wt(520);
      chk(32'({buzz, fmsg}), 32'h0000_0000);
      wr(CTRL_ADDR, 32'h0000_00E0);
      wt(400);
      chk(32'(fmsg), 32'h0000_0000);
      wt(120);
      chk(32'({oe, fmsg}), 32'h0000_0020);
      @(posedge aclk) rev <= 1'b0;
      wr(CLEAR_ADDR, 32'h0000_007F);
      wr(OUTPUT_ADDR, 32'h0000_0001);
      wt(2);
      chk(32'({oe, fmsg}), 32'h0000_0080);
      test_done();
   end
endmodule : prot_supervisor_test
